//--- rtl/lmc_params.svh
// Constants for the line maintenance code and error control block.
// Assumes a single 200 MHz clock and an 8-bit register port.
//
// Overview of operation
// - Transmit length field picks 5, 6, 7, 8 bits
// - Activate length field picks matched low bits
// - Deactivate length field, reset value 01
// - Low code bits repeat continuously on transmit
// - Activate code supplies receive compare, reset 00001
// - Deactivate code supplies compare, reset 001001
// - Violation bit rise inserts exactly one violation
// - Logic error bit rise inserts one error
// - Excess-zero select: 0 ANSI, 1 FCC
// - Error source field selects counted events
// - Mode bit: 0 manual, 1 automatic report
// - Transfer bit rise copies count, clears counter
// - Loop code sent only when pattern is 11
`ifndef LMC_PARAMS_SVH
`define LMC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define LMC_ADDR_LEN_CFG    8'h0C
`define LMC_ADDR_TX_CODE    8'h0D
`define LMC_ADDR_RX_ACT     8'h0E
`define LMC_ADDR_RX_DEACT   8'h0F
`define LMC_ADDR_ERR_CTL    8'h10
`define LMC_ADDR_PAT_SEL    8'h1A
`define LMC_ADDR_CNT_LOW    8'h1B
`define LMC_ADDR_CNT_HIGH   8'h1C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LMC_TX_LEN_LSB      4
`define LMC_RX_ACT_LEN_LSB  2
`define LMC_RX_DEACT_LEN_LSB 0
`define LMC_VIOL_BIT        6
`define LMC_LERR_BIT        5
`define LMC_EXZ_BIT         4
`define LMC_ERR_SEL_LSB     2
`define LMC_MODE_BIT        1
`define LMC_TRF_BIT         0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define LMC_LEN_CFG_RST     6'h01
`define LMC_TX_CODE_RST     8'h01
`define LMC_RX_ACT_RST      8'h01
`define LMC_RX_DEACT_RST    8'h09
`define LMC_ERR_CTL_RST     7'h00
`define LMC_CNT_MAX         16'hFFFF

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define LMC_CLK_HZ          200000000
`define LMC_ONE_SEC_MS      1000
`define LMC_ONE_SEC_CYCLES  (`LMC_CLK_HZ / 1000 * `LMC_ONE_SEC_MS)
`define LMC_MATCH_REPEATS   3'h4

`endif

//--- rtl/lmc_pkg.sv
// Types shared by the line maintenance code and error control block.
// Assumes the constants header is included by each design file.
package lmc_pkg;

	typedef logic [7:0] lmc_byte_t;

	typedef enum logic [1:0] {
		LMC_SRC_PRBS,
		LMC_SRC_EXZ,
		LMC_SRC_CV,
		LMC_SRC_BOTH
	} lmc_err_src_e;

	typedef enum logic [1:0] {
		LMC_PAT_NORMAL,
		LMC_PAT_ONES,
		LMC_PAT_PRBS,
		LMC_PAT_LOOP
	} lmc_pat_e;

	// Length selector 00..11 means 5..8 code bits
	function automatic logic [3:0] lmc_code_len(input logic [1:0] sel);
		lmc_code_len = 4'h5 + {2'h0, sel};
	endfunction

	function automatic lmc_byte_t lmc_code_mask(input logic [1:0] sel);
		lmc_code_mask = 8'hFF >> (2'h3 - sel);
	endfunction

endpackage

//--- rtl/lmc_code_gen.sv
// Serialiser that repeats the low bits of a loop code, MSB of the code first.
// Assumes advance is a one-cycle pulse per transmitted line bit.
`include "lmc_params.svh"

module lmc_code_gen import lmc_pkg::*; (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire lmc_byte_t  code,
	input  wire logic [1:0] lenSel,
	input  wire logic       advance,
	output      logic       codeBit
);

	logic [2:0] idx_ff;
	logic [2:0] nxt_idx;
	logic [3:0] len;
	logic [3:0] pos;
	logic       last;

	assign len     = lmc_code_len(lenSel);
	// Length may shrink under a running index; >= wraps it at once
	assign last    = ({1'b0, idx_ff} >= len - 4'h1);
	assign nxt_idx = last ? 3'h0 : idx_ff + 3'h1;
	assign pos     = len - 4'h1 - {1'b0, idx_ff};
	assign codeBit = code[pos[2:0]];

	always_ff @(posedge mclk) begin
		if (rst) begin
			idx_ff <= 3'h0;
		end else if (advance) begin
			idx_ff <= nxt_idx;
		end
	end

	property p_code_wrap;
		@(posedge mclk) disable iff (rst)
		advance && last |=> idx_ff == 3'h0;
	endproperty
	a_code_wrap: assert property (p_code_wrap) else $error("Loop code did not wrap");

endmodule

//--- rtl/lmc_code_match.sv
// Detector for a repeating receive loop code of 5 to 8 bits.
// Assumes bitEn is a one-cycle pulse per received bit from same-clock logic.
`include "lmc_params.svh"

module lmc_code_match import lmc_pkg::*; (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire lmc_byte_t  code,
	input  wire logic [1:0] lenSel,
	input  wire logic       bitEn,
	input  wire logic       rxBit,
	output      logic       detected
);

	lmc_byte_t  hist_ff;
	logic [3:0] phase_ff;
	logic [2:0] reps_ff;
	logic       det_ff;
	lmc_byte_t  nxt_hist;
	logic [3:0] nxt_phase;
	logic [2:0] nxt_reps;
	logic [3:0] len;
	logic       hit;
	logic       counted;
	logic       lost;

	assign len      = lmc_code_len(lenSel);
	assign nxt_hist = {hist_ff[6:0], rxBit};
	assign hit      = ((nxt_hist ^ code) & lmc_code_mask(lenSel)) == 8'h00;
	// Hits inside a period are ignored, so codes with inner repeats still count
	assign counted  = hit && (reps_ff == 3'h0 || phase_ff == len);
	assign lost     = !counted && phase_ff >= len;
	assign nxt_phase = counted ? 4'h1 : (phase_ff == 4'hF ? phase_ff : phase_ff + 4'h1);
	assign nxt_reps = !counted ? (lost ? 3'h0 : reps_ff) :
		(reps_ff == `LMC_MATCH_REPEATS ? reps_ff : reps_ff + 3'h1);
	assign detected = det_ff;

	always_ff @(posedge mclk) begin
		if (rst) begin
			hist_ff  <= 8'h00;
			phase_ff <= 4'h0;
			reps_ff  <= 3'h0;
			det_ff   <= 1'b0;
		end else if (bitEn) begin
			hist_ff  <= nxt_hist;
			phase_ff <= nxt_phase;
			reps_ff  <= nxt_reps;
			det_ff   <= (nxt_reps == `LMC_MATCH_REPEATS);
		end
	end

	property p_match_loss;
		@(posedge mclk) disable iff (rst)
		bitEn && lost |=> !det_ff && reps_ff == 3'h0;
	endproperty
	a_match_loss: assert property (p_match_loss) else $error("Detect held after code loss");

endmodule

//--- rtl/lmc_maint_ctrl.sv
// Maintenance control: loop code registers, error insertion, error counter.
// Assumes an 8-bit register port with read data one cycle after the strobe,
// and line bit enables and error events from logic on the same clock.
//
// Implementation choice: the address-and-strobe port.
`include "lmc_params.svh"

module lmc_maint_ctrl import lmc_pkg::*; #(
	parameter int unsigned ONE_SEC_CYCLES = `LMC_ONE_SEC_CYCLES
) (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire lmc_byte_t  addr,
	input  wire lmc_byte_t  wrData,
	input  wire logic       wrStb,
	input  wire logic       rdStb,
	output      lmc_byte_t  rdData,
	input  wire logic       txBitEn,
	input  wire logic       txDataIn,
	input  wire logic       prbsBit,
	output      logic       txLineBit,
	output      logic       txViolation,
	input  wire logic       rxBitEn,
	input  wire logic       rxBit,
	output      logic       activateDetected,
	output      logic       deactivateDetected,
	input  wire logic       prbsErrEvt,
	input  wire logic       exzErrEvt,
	input  wire logic       cvErrEvt,
	output      logic       excessZeroDefinition,
	output      logic       countTransferred
);

	// ----------------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------------
	logic [5:0]  lenCfg_ff;
	lmc_byte_t   txCode_ff;
	lmc_byte_t   rxAct_ff;
	lmc_byte_t   rxDeact_ff;
	logic [6:0]  errCtl_ff;
	logic [1:0]  patSel_ff;
	logic [15:0] cnt_ff;
	logic [15:0] result_ff;
	logic [27:0] tmr_ff;
	logic        violPend_ff;
	logic        lerrPend_ff;
	lmc_byte_t   rdData_ff;
	logic        txLineBit_ff;
	logic        txViolation_ff;
	logic        countTransferred_ff;

	// ----------------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------------
	logic        wrLenCfg;
	logic        wrTxCode;
	logic        wrRxAct;
	logic        wrRxDeact;
	logic        wrErrCtl;
	logic        wrPatSel;
	logic        violRise;
	logic        lerrRise;
	logic        trfRise;
	logic        tick;
	logic        xfer;
	logic        errEvt;
	logic        prbsSlot;
	logic        loopBit;
	logic        nxtLineBit;
	logic        nxt_violPend;
	logic        nxt_lerrPend;
	logic [15:0] nxt_cnt;
	lmc_byte_t   rdMux;
	lmc_err_src_e errSel;
	lmc_pat_e    patSel;

	assign wrLenCfg  = wrStb && addr == `LMC_ADDR_LEN_CFG;
	assign wrTxCode  = wrStb && addr == `LMC_ADDR_TX_CODE;
	assign wrRxAct   = wrStb && addr == `LMC_ADDR_RX_ACT;
	assign wrRxDeact = wrStb && addr == `LMC_ADDR_RX_DEACT;
	assign wrErrCtl  = wrStb && addr == `LMC_ADDR_ERR_CTL;
	assign wrPatSel  = wrStb && addr == `LMC_ADDR_PAT_SEL;

	// Only a 0-to-1 write counts; holding 1 gives nothing more
	assign violRise = wrErrCtl && wrData[`LMC_VIOL_BIT] && !errCtl_ff[`LMC_VIOL_BIT];
	assign lerrRise = wrErrCtl && wrData[`LMC_LERR_BIT] && !errCtl_ff[`LMC_LERR_BIT];
	assign trfRise  = wrErrCtl && wrData[`LMC_TRF_BIT] && !errCtl_ff[`LMC_TRF_BIT];

	assign errSel = lmc_err_src_e'(errCtl_ff[`LMC_ERR_SEL_LSB +: 2]);
	assign patSel = lmc_pat_e'(patSel_ff);

	// ----------------------------------------------------------------------
	// Transmit path
	// ----------------------------------------------------------------------
	lmc_code_gen u_tx_code (
		.mclk    (mclk),
		.rst     (rst),
		.code    (txCode_ff),
		.lenSel  (lenCfg_ff[`LMC_TX_LEN_LSB +: 2]),
		.advance (txBitEn && patSel == LMC_PAT_LOOP),
		.codeBit (loopBit)
	);

	assign prbsSlot   = txBitEn && patSel == LMC_PAT_PRBS;
	// Logic error flips one PRBS bit; it waits for PRBS to be selected
	assign nxtLineBit = (patSel == LMC_PAT_LOOP) ? loopBit :
		(patSel == LMC_PAT_PRBS) ? (prbsBit ^ lerrPend_ff) :
		(patSel == LMC_PAT_ONES) ? 1'b1 : txDataIn;
	// Set wins over the clear of the same cycle
	assign nxt_violPend = violRise || (violPend_ff && !txBitEn);
	assign nxt_lerrPend = lerrRise || (lerrPend_ff && !prbsSlot);

	always_ff @(posedge mclk) begin
		if (rst) begin
			violPend_ff    <= 1'b0;
			lerrPend_ff    <= 1'b0;
			txLineBit_ff   <= 1'b0;
			txViolation_ff <= 1'b0;
		end else begin
			violPend_ff <= nxt_violPend;
			lerrPend_ff <= nxt_lerrPend;
			if (txBitEn) begin
				txLineBit_ff   <= nxtLineBit;
				txViolation_ff <= violPend_ff;
			end
		end
	end

	// ----------------------------------------------------------------------
	// Receive code detection
	// ----------------------------------------------------------------------
	lmc_code_match u_rx_act (
		.mclk     (mclk),
		.rst      (rst),
		.code     (rxAct_ff),
		.lenSel   (lenCfg_ff[`LMC_RX_ACT_LEN_LSB +: 2]),
		.bitEn    (rxBitEn),
		.rxBit    (rxBit),
		.detected (activateDetected)
	);

	lmc_code_match u_rx_deact (
		.mclk     (mclk),
		.rst      (rst),
		.code     (rxDeact_ff),
		.lenSel   (lenCfg_ff[`LMC_RX_DEACT_LEN_LSB +: 2]),
		.bitEn    (rxBitEn),
		.rxBit    (rxBit),
		.detected (deactivateDetected)
	);

	// ----------------------------------------------------------------------
	// Error counter and one-second timer
	// ----------------------------------------------------------------------
	assign tick   = tmr_ff == 28'(ONE_SEC_CYCLES - 1);
	assign xfer   = trfRise || (errCtl_ff[`LMC_MODE_BIT] && tick);
	assign errEvt = (errSel == LMC_SRC_PRBS) ? prbsErrEvt :
		(errSel == LMC_SRC_EXZ) ? exzErrEvt :
		(errSel == LMC_SRC_CV) ? cvErrEvt : (cvErrEvt || exzErrEvt);
	// An event in the transfer cycle starts the new count, so none is lost;
	// the counter saturates rather than wrapping
	assign nxt_cnt = xfer ? {15'h0000, errEvt} :
		(errEvt && cnt_ff != `LMC_CNT_MAX) ? cnt_ff + 16'h0001 : cnt_ff;

	always_ff @(posedge mclk) begin
		if (rst) begin
			tmr_ff              <= 28'h0000000;
			cnt_ff              <= 16'h0000;
			result_ff           <= 16'h0000;
			countTransferred_ff <= 1'b0;
		end else begin
			tmr_ff              <= tick ? 28'h0000000 : tmr_ff + 28'h0000001;
			cnt_ff              <= nxt_cnt;
			countTransferred_ff <= xfer;
			if (xfer) begin
				result_ff <= cnt_ff;
			end
		end
	end

	// ----------------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			lenCfg_ff  <= `LMC_LEN_CFG_RST;
			txCode_ff  <= `LMC_TX_CODE_RST;
			rxAct_ff   <= `LMC_RX_ACT_RST;
			rxDeact_ff <= `LMC_RX_DEACT_RST;
			errCtl_ff  <= `LMC_ERR_CTL_RST;
			patSel_ff  <= 2'h0;
		end else begin
			if (wrLenCfg) begin
				lenCfg_ff <= wrData[5:0];
			end
			if (wrTxCode) begin
				txCode_ff <= wrData;
			end
			if (wrRxAct) begin
				rxAct_ff <= wrData;
			end
			if (wrRxDeact) begin
				rxDeact_ff <= wrData;
			end
			if (wrErrCtl) begin
				errCtl_ff <= wrData[6:0];
			end
			if (wrPatSel) begin
				patSel_ff <= wrData[1:0];
			end
		end
	end

	always_comb begin
		unique case (addr)
			`LMC_ADDR_LEN_CFG:  rdMux = {2'h0, lenCfg_ff};
			`LMC_ADDR_TX_CODE:  rdMux = txCode_ff;
			`LMC_ADDR_RX_ACT:   rdMux = rxAct_ff;
			`LMC_ADDR_RX_DEACT: rdMux = rxDeact_ff;
			`LMC_ADDR_ERR_CTL:  rdMux = {1'b0, errCtl_ff};
			`LMC_ADDR_PAT_SEL:  rdMux = {6'h00, patSel_ff};
			`LMC_ADDR_CNT_LOW:  rdMux = result_ff[7:0];
			`LMC_ADDR_CNT_HIGH: rdMux = result_ff[15:8];
			default:            rdMux = 8'h00;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdData_ff <= 8'h00;
		end else begin
			rdData_ff <= rdStb ? rdMux : 8'h00;
		end
	end

	assign rdData               = rdData_ff;
	assign txLineBit            = txLineBit_ff;
	assign txViolation          = txViolation_ff;
	assign excessZeroDefinition = errCtl_ff[`LMC_EXZ_BIT];
	assign countTransferred     = countTransferred_ff;

	// ----------------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------------
	property p_tx_loop_bit;
		@(posedge mclk) disable iff (rst)
		txBitEn && patSel == LMC_PAT_LOOP |=> txLineBit_ff == $past(loopBit);
	endproperty
	a_tx_loop_bit: assert property (p_tx_loop_bit) else $error("Loop code bit not sent");

	property p_viol_once;
		@(posedge mclk) disable iff (rst)
		txBitEn && violPend_ff && !violRise |=> txViolation_ff && !violPend_ff;
	endproperty
	a_viol_once: assert property (p_viol_once) else $error("Violation not inserted once");

	property p_viol_quiet;
		@(posedge mclk) disable iff (rst)
		txBitEn && !violPend_ff |=> !txViolation_ff;
	endproperty
	a_viol_quiet: assert property (p_viol_quiet) else $error("Violation without request");

	property p_logic_err;
		@(posedge mclk) disable iff (rst)
		prbsSlot && lerrPend_ff |=> txLineBit_ff == !$past(prbsBit);
	endproperty
	a_logic_err: assert property (p_logic_err) else $error("Logic error not inserted");

	property p_manual_xfer;
		@(posedge mclk) disable iff (rst)
		trfRise |=> result_ff == $past(cnt_ff) && cnt_ff <= 16'h0001 && countTransferred_ff;
	endproperty
	a_manual_xfer: assert property (p_manual_xfer) else $error("Transfer did not copy count");

	property p_auto_xfer;
		@(posedge mclk) disable iff (rst)
		errCtl_ff[`LMC_MODE_BIT] && tick |=> result_ff == $past(cnt_ff) && countTransferred_ff;
	endproperty
	a_auto_xfer: assert property (p_auto_xfer) else $error("Auto report missed expiry");

	property p_manual_hold;
		@(posedge mclk) disable iff (rst)
		!errCtl_ff[`LMC_MODE_BIT] && !trfRise |=> $stable(result_ff);
	endproperty
	a_manual_hold: assert property (p_manual_hold) else $error("Result changed unrequested");

	property p_count_src;
		@(posedge mclk) disable iff (rst)
		!xfer && errSel == LMC_SRC_PRBS && prbsErrEvt && cnt_ff != `LMC_CNT_MAX
			|=> cnt_ff == $past(cnt_ff) + 16'h0001;
	endproperty
	a_count_src: assert property (p_count_src) else $error("PRBS error not counted");

	property p_reserved_zero;
		@(posedge mclk) disable iff (rst)
		rdStb && (addr == `LMC_ADDR_LEN_CFG || addr == `LMC_ADDR_ERR_CTL)
			|=> rdData_ff[7] == 1'b0 && ($past(addr) != `LMC_ADDR_LEN_CFG || !rdData_ff[6])
			##1 rdData_ff == 8'h00 || $past(rdStb);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bit read one");

	property p_tx_len_read;
		@(posedge mclk) disable iff (rst)
		wrLenCfg ##1 !wrLenCfg ##1 rdStb && addr == `LMC_ADDR_LEN_CFG && !wrStb
			|=> rdData_ff == ($past(wrData, 3) & 8'h3F);
	endproperty
	a_tx_len_read: assert property (p_tx_len_read) else $error("Length field readback wrong");

	property p_count_clear;
		@(posedge mclk) disable iff (rst)
		trfRise && !errEvt |=> cnt_ff == 16'h0000 && countTransferred_ff;
	endproperty
	a_count_clear: assert property (p_count_clear) else $error("Count not cleared");

	property p_count_exz;
		@(posedge mclk) disable iff (rst)
		!xfer && errSel == LMC_SRC_EXZ && exzErrEvt && cnt_ff != `LMC_CNT_MAX
			|=> cnt_ff == $past(cnt_ff) + 16'h0001;
	endproperty
	a_count_exz: assert property (p_count_exz) else $error("Excess zero not counted");

	property p_count_cv;
		@(posedge mclk) disable iff (rst)
		!xfer && errSel == LMC_SRC_CV && cvErrEvt && cnt_ff != `LMC_CNT_MAX
			|=> cnt_ff == $past(cnt_ff) + 16'h0001;
	endproperty
	a_count_cv: assert property (p_count_cv) else $error("Code violation not counted");

	property p_count_both;
		@(posedge mclk) disable iff (rst)
		!xfer && errSel == LMC_SRC_BOTH && (cvErrEvt || exzErrEvt) && cnt_ff != `LMC_CNT_MAX
			|=> cnt_ff == $past(cnt_ff) + 16'h0001;
	endproperty
	a_count_both: assert property (p_count_both) else $error("Combined error not counted");

	property p_count_ignore;
		@(posedge mclk) disable iff (rst)
		!xfer && errSel == LMC_SRC_PRBS && !prbsErrEvt |=> $stable(cnt_ff);
	endproperty
	a_count_ignore: assert property (p_count_ignore) else $error("Count moved without event");

	property p_viol_pend;
		@(posedge mclk) disable iff (rst)
		violRise |=> violPend_ff;
	endproperty
	a_viol_pend: assert property (p_viol_pend) else $error("Violation request lost");

	property p_viol_hold;
		@(posedge mclk) disable iff (rst)
		wrErrCtl && errCtl_ff[`LMC_VIOL_BIT] && !violPend_ff |=> !violPend_ff;
	endproperty
	a_viol_hold: assert property (p_viol_hold) else $error("Held violation bit requested");

	property p_lerr_hold;
		@(posedge mclk) disable iff (rst)
		wrErrCtl && errCtl_ff[`LMC_LERR_BIT] && !lerrPend_ff |=> !lerrPend_ff;
	endproperty
	a_lerr_hold: assert property (p_lerr_hold) else $error("Held error bit requested");

endmodule

//--- tb/lmc_far_end.sv
// Far-end line terminal model: paces line bits, sends receive codes.
// Assumes it shares mclk and rst with the block under test.
module lmc_far_end import lmc_pkg::*; (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        txLineBit,
	input  wire logic        txViolation,
	input  wire logic        sendOn,
	input  wire lmc_byte_t   sendCode,
	input  wire logic [3:0]  sendLen,
	output      logic        txBitEn,
	output      logic        rxBitEn,
	output      logic        rxBit,
	output      logic [31:0] txHist,
	output      int          violCount
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [1:0] div;
	logic [3:0] idx;
	logic       lastViol;

	// ----------------------------------------------------------------
	// Line pacing, one bit every four clocks
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			div <= 2'h0;
			idx <= 4'h0;
			txBitEn <= 1'b0;
			rxBitEn <= 1'b0;
			rxBit <= 1'b0;
			txHist <= 32'h0;
			violCount <= 0;
			lastViol <= 1'b0;
		end else begin
			div <= div + 2'h1;
			txBitEn <= (div == 2'h3);
			rxBitEn <= (div == 2'h3);
			lastViol <= txViolation;
			if (txViolation && !lastViol)
				violCount <= violCount + 1;
			if (txBitEn)
				txHist <= {txHist[30:0], txLineBit};
			if (div == 2'h3) begin
				// Idle line toggles so no stale level can fake a code
				rxBit <= sendOn ? sendCode[sendLen - 4'h1 - idx] : ~rxBit;
				idx <= (!sendOn || idx + 4'h1 >= sendLen) ? 4'h0 : idx + 4'h1;
			end
		end
	end
endmodule

//--- tb/lmc_maint_ctrl_tb_top.sv
// Self-checking bench for the maintenance control block.
// Assumes the far-end model paces line bits; timer shortened to 50 cycles.
`include "lmc_params.svh"

module lmc_maint_ctrl_tb_top import lmc_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;

	logic        mclk, rst, wrStb, rdStb, txBitEn, txDataIn, prbsBit;
	logic        txLineBit, txViolation, rxBitEn, rxBit;
	logic        activateDetected, deactivateDetected;
	logic        prbsErrEvt, exzErrEvt, cvErrEvt;
	logic        excessZeroDefinition, countTransferred, sendOn;
	lmc_byte_t   addr, wrData, rdData, sendCode;
	logic [3:0]  sendLen;
	logic [31:0] txHist;
	int          violCount, fails, n_checks, cycles, xferCount;

	lmc_maint_ctrl #(.ONE_SEC_CYCLES(50)) dut (.mclk(mclk), .rst(rst), .addr(addr),
		.wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
		.txBitEn(txBitEn), .txDataIn(txDataIn), .prbsBit(prbsBit),
		.txLineBit(txLineBit), .txViolation(txViolation), .rxBitEn(rxBitEn),
		.rxBit(rxBit), .activateDetected(activateDetected),
		.deactivateDetected(deactivateDetected), .prbsErrEvt(prbsErrEvt),
		.exzErrEvt(exzErrEvt), .cvErrEvt(cvErrEvt),
		.excessZeroDefinition(excessZeroDefinition),
		.countTransferred(countTransferred));

	lmc_far_end far (.mclk(mclk), .rst(rst), .txLineBit(txLineBit),
		.txViolation(txViolation), .sendOn(sendOn), .sendCode(sendCode),
		.sendLen(sendLen), .txBitEn(txBitEn), .rxBitEn(rxBitEn), .rxBit(rxBit),
		.txHist(txHist), .violCount(violCount));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// ----------------------------------------------------------------
	// Bus tasks, checks and closing
	// ----------------------------------------------------------------
	task automatic end_sim;
		$display("Checks made %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input lmc_byte_t a, input lmc_byte_t d);
		@(posedge mclk);
		addr <= a;
		wrData <= d;
		wrStb <= 1'b1;
		@(posedge mclk);
		wrStb <= 1'b0;
	endtask

	task automatic rdc(input lmc_byte_t a, input lmc_byte_t exp);
		@(posedge mclk);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge mclk);
		rdStb <= 1'b0;
		#1;
		chk(rdData, exp);
	endtask

	task automatic ev(input logic p, input logic e, input logic c);
		@(posedge mclk);
		prbsErrEvt <= p;
		exzErrEvt <= e;
		cvErrEvt <= c;
		@(posedge mclk);
		prbsErrEvt <= 1'b0;
		exzErrEvt <= 1'b0;
		cvErrEvt <= 1'b0;
	endtask

	task automatic bits(input int n);
		repeat (n * 4) @(posedge mclk);
	endtask

	// Bounded wait: 0 transfer pulse, 1 activate, 2 deactivate
	task automatic waitFor(input int sel, input int lim);
		int i;
		for (i = 0; i < lim; i++) begin
			@(posedge mclk);
			#1;
			if ((sel == 0 && countTransferred === 1'b1) ||
			    (sel == 1 && activateDetected === 1'b1) ||
			    (sel == 2 && deactivateDetected === 1'b1))
				break;
		end
		chk(i < lim, 1);
	endtask

	task automatic sendRx(input lmc_byte_t c, input logic [3:0] n);
		@(posedge mclk);
		sendOn <= 1'b0;
		bits(2);
		sendCode <= c;
		sendLen <= n;
		sendOn <= 1'b1;
	endtask

	always @(posedge mclk) begin
		cycles++;
		if (countTransferred === 1'b1)
			xferCount++;
		if (cycles == 20000) begin
			fails++;
			end_sim();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		int k, i, n, per, v0, x0;
		rst <= 1'b1;
		addr <= 8'h00;
		wrData <= 8'h00;
		wrStb <= 1'b0;
		rdStb <= 1'b0;
		txDataIn <= 1'b0;
		prbsBit <= 1'b0;
		prbsErrEvt <= 1'b0;
		exzErrEvt <= 1'b0;
		cvErrEvt <= 1'b0;
		sendOn <= 1'b0;
		sendCode <= 8'h00;
		sendLen <= 4'h5;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;

		rdc(`LMC_ADDR_LEN_CFG, 8'h01);
		rdc(`LMC_ADDR_TX_CODE, 8'h01);
		rdc(`LMC_ADDR_RX_ACT, 8'h01);
		rdc(`LMC_ADDR_RX_DEACT, 8'h09);
		rdc(`LMC_ADDR_ERR_CTL, 8'h00);
		@(posedge mclk);
		#1;
		chk(rdData, 8'h00);
		wr(`LMC_ADDR_LEN_CFG, 8'hFF);
		rdc(`LMC_ADDR_LEN_CFG, 8'h3F);
		wr(`LMC_ADDR_ERR_CTL, 8'h80);
		rdc(`LMC_ADDR_ERR_CTL, 8'h00);
		wr(8'h20, 8'h55);
		rdc(8'h20, 8'h00);
		for (k = 0; k < 3; k++) begin
			wr(`LMC_ADDR_TX_CODE + k[7:0], 8'h5A ^ k[7:0]);
			rdc(`LMC_ADDR_TX_CODE + k[7:0], 8'h5A ^ k[7:0]);
		end
		$display("Test registers done");

		// Loop code repeats with the period of the selected length
		wr(`LMC_ADDR_TX_CODE, 8'h35);
		wr(`LMC_ADDR_PAT_SEL, 8'h03);
		for (k = 0; k < 4; k++) begin
			wr(`LMC_ADDR_LEN_CFG, {2'h0, k[1:0], 4'h1});
			bits(40);
			n = 5 + k;
			per = 0;
			for (i = 0; i < 16; i++)
				if (txHist[i] !== txHist[i + n])
					per++;
			chk(per, 0);
			chk($countones(txHist & ((32'h1 << n) - 1)), $countones(8'h35 & ((9'h1 << n) - 1)));
		end
		wr(`LMC_ADDR_PAT_SEL, 8'h01);
		bits(40);
		chk(txHist, 32'hFFFFFFFF);
		wr(`LMC_ADDR_PAT_SEL, 8'h00);
		bits(40);
		chk(txHist, 32'h00000000);
		@(posedge mclk);
		txDataIn <= 1'b1;
		bits(40);
		chk(txHist, 32'hFFFFFFFF);
		$display("Test transmit code done");

		wr(`LMC_ADDR_PAT_SEL, 8'h02);
		bits(40);
		chk($countones(txHist), 0);
		wr(`LMC_ADDR_ERR_CTL, 8'h20);
		bits(20);
		chk($countones(txHist), 1);
		wr(`LMC_ADDR_ERR_CTL, 8'h20);
		bits(40);
		chk($countones(txHist), 0);
		wr(`LMC_ADDR_ERR_CTL, 8'h00);
		wr(`LMC_ADDR_ERR_CTL, 8'h20);
		bits(20);
		chk($countones(txHist), 1);
		v0 = violCount;
		wr(`LMC_ADDR_ERR_CTL, 8'h40);
		bits(8);
		chk(violCount, v0 + 1);
		wr(`LMC_ADDR_ERR_CTL, 8'h40);
		bits(8);
		chk(violCount, v0 + 1);
		wr(`LMC_ADDR_ERR_CTL, 8'h00);
		wr(`LMC_ADDR_ERR_CTL, 8'h40);
		bits(8);
		chk(violCount, v0 + 2);
		$display("Test error insertion done");

		// Event mix gives 1, 3, 5, 7 for sources 00..11
		for (k = 0; k < 4; k++) begin
			wr(`LMC_ADDR_ERR_CTL, {4'h0, k[1:0], 2'h0});
			wr(`LMC_ADDR_ERR_CTL, {4'h0, k[1:0], 2'h1});
			wr(`LMC_ADDR_ERR_CTL, {4'h0, k[1:0], 2'h0});
			ev(1'b1, 1'b0, 1'b0);
			repeat (2) ev(1'b0, 1'b1, 1'b0);
			repeat (4) ev(1'b0, 1'b0, 1'b1);
			ev(1'b0, 1'b1, 1'b1);
			x0 = xferCount;
			wr(`LMC_ADDR_ERR_CTL, {4'h0, k[1:0], 2'h1});
			bits(1);
			chk(xferCount, x0 + 1);
			rdc(`LMC_ADDR_CNT_LOW, 8'(2 * k + 1));
			rdc(`LMC_ADDR_CNT_HIGH, 8'h00);
			ev(1'b1, 1'b1, 1'b1);
			wr(`LMC_ADDR_ERR_CTL, {4'h0, k[1:0], 2'h1});
			rdc(`LMC_ADDR_CNT_LOW, 8'(2 * k + 1));
		end
		wr(`LMC_ADDR_ERR_CTL, 8'h02);
		waitFor(0, 60);
		repeat (3) ev(1'b1, 1'b0, 1'b0);
		waitFor(0, 60);
		rdc(`LMC_ADDR_CNT_LOW, 8'h03);
		wr(`LMC_ADDR_ERR_CTL, 8'h10);
		bits(1);
		chk(excessZeroDefinition, 1'b1);
		rdc(`LMC_ADDR_ERR_CTL, 8'h10);
		$display("Test counter done");

		wr(`LMC_ADDR_LEN_CFG, 8'h01);
		wr(`LMC_ADDR_RX_ACT, 8'h01);
		wr(`LMC_ADDR_RX_DEACT, 8'h09);
		sendRx(8'h01, 4'h5);
		waitFor(1, 300);
		chk(deactivateDetected, 1'b0);
		sendRx(8'h09, 4'h6);
		waitFor(2, 300);
		chk(activateDetected, 1'b0);
		wr(`LMC_ADDR_LEN_CFG, 8'h0D);
		wr(`LMC_ADDR_RX_ACT, 8'h96);
		sendRx(8'h96, 4'h8);
		waitFor(1, 400);
		$display("Test receive detect done");
		end_sim();
	end
endmodule
